// *** rtl/dtc_pkg.sv ***
// dual timer/counter constants, register map and field layout
package dtc_pkg;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_AUX  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_T0L  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_T0H  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_T1L  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_T1H  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STS  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h20;
  // mode nibble layout
  localparam int NIB_W    = 4;
  localparam int GATE_BIT = 3;
  localparam int CT_BIT   = 2;
  localparam int MODE_MSB = 1;
  localparam int MODE_LSB = 0;
  localparam logic [1:0] MODE_13     = 2'h0;
  localparam logic [1:0] MODE_16     = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;
  // control/flag register layout
  localparam int CTRL_TF1    = 7;
  localparam int CTRL_TR1    = 6;
  localparam int CTRL_TF0    = 5;
  localparam int CTRL_TR0    = 4;
  localparam int CTRL_IE0    = 1;
  localparam int CTRL_IT0    = 0;
  localparam int CTRL_STRIDE = 2;
  // auxiliary clock select
  localparam int AUX_FAST0 = 7;
  localparam logic [7:0] AUX_MASK = 8'hC0;
  // vector acknowledge and status order
  localparam int ACK_IE0 = 0;
  localparam int ACK_TF0 = 1;
  localparam int ACK_TF1 = 3;
  // reset values
  localparam logic [7:0]  RST_MODE = 8'h00;
  localparam logic [7:0]  RST_CTRL = 8'h00;
  localparam logic [7:0]  RST_AUX  = 8'h00;
  localparam logic [15:0] RST_CNT  = 16'h0000;
  localparam logic [3:0]  RST_MASK = 4'h0;
  // prescaler
  localparam int DIV_RATIO = 12;
  localparam int DIV_W     = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_RATIO - 1);
endpackage : dtc_pkg

// *** rtl/dtc_tick_if.sv ***
// tick and pin-event carrier between synchroniser and timer core
`timescale 1ns/1ns
`default_nettype none
interface dtc_tick_if;
  logic       tick;     // one-cycle prescaler pulse
  logic [1:0] cnt_fall; // count pin falling edge, per timer
  logic [1:0] ext_fall; // request pin falling edge
  logic [1:0] ext_lvl;  // synchronised request pin level
  modport src (output tick, cnt_fall, ext_fall, ext_lvl);
  modport dst (input tick, cnt_fall, ext_fall, ext_lvl);
endinterface : dtc_tick_if
`default_nettype wire

// *** rtl/dtc_sync.sv ***
// pin synchroniser, falling edge detector and divide-by-12 prescaler
`timescale 1ns/1ns
`default_nettype none
module dtc_sync
  import dtc_pkg::*;
(
  // clock, reset, freeze
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // pins, asynchronous to pclk
  input  wire logic [1:0] count_pin,
  input  wire logic [1:0] ext_request_pin_n,
  // events toward the core
  dtc_tick_if.src         t
);
  typedef struct packed {
    logic [3:0]       ff1;
    logic [3:0]       ff2;
    logic [3:0]       ff3;
    logic [DIV_W-1:0] div;
    logic             tick;
    logic [1:0]       cfall;
    logic [1:0]       efall;
  } dtc_sync_type;

  dtc_sync_type s;
  dtc_sync_type n;
  logic [3:0]   fall;

  // ff1 feeds ff2 only; edges are taken between ff2 and ff3
  always_comb begin
    n       = s;
    n.ff1   = {ext_request_pin_n, count_pin};
    n.ff2   = s.ff1;
    n.ff3   = s.ff2;
    fall    = s.ff3 & ~s.ff2;
    n.cfall = fall[1:0];
    n.efall = fall[3:2];
    n.tick  = (s.div == DIV_LAST);
    n.div   = (s.div == DIV_LAST) ? '0 : s.div + DIV_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // chain resets to the pins' idle high level, so no false request follows reset
      s <= '{ff1: '1, ff2: '1, ff3: '1, div: '0, tick: 1'b0, cfall: '0, efall: '0};
    end else if (ce) begin
      s <= n;
    end
  end

  assign t.tick     = s.tick;
  assign t.cnt_fall = s.cfall;
  assign t.ext_fall = s.efall;
  assign t.ext_lvl  = s.ff2[3:2];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  edge_once_a: assert property (s.cfall[0] |=> !s.cfall[0])
    else $error("count edge pulse longer than one cycle");
  tick_gap_a: assert property (s.tick |=> !s.tick)
    else $error("prescaler ticks back to back");
endmodule : dtc_sync
`default_nettype wire

// *** rtl/dtc_top.sv ***
// dual timer/counter core with apb register file and interrupt
`timescale 1ns/1ns
`default_nettype none
module dtc_top
  import dtc_pkg::*;
(
  // clock, reset, freeze
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // apb slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // external pins
  input  wire logic [1:0]        count_pin,
  input  wire logic [1:0]        ext_request_pin_n,
  // vectoring and interrupt
  input  wire logic [3:0]        vec_ack,
  output logic      [3:0]        flag_req,
  output logic                   irq
);
  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  timer_run_and_flags;
    logic [7:0]  aux;
    logic [15:0] cnt0;
    logic [15:0] cnt1;
    logic [3:0]  sts;
    logic [3:0]  mask;
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
    logic        irq;
  } dtc_state_type;

  localparam dtc_state_type ST_RST = '{
    mode:  RST_MODE,
    timer_run_and_flags:  RST_CTRL,
    aux:   RST_AUX,
    cnt0:  RST_CNT,
    cnt1:  RST_CNT,
    sts:   '0,
    mask:  RST_MASK,
    rdata: '0,
    rdy:   1'b0,
    err:   1'b0,
    irq:   1'b0
  };

  dtc_state_type s;
  dtc_state_type n;

  logic        setup;
  logic        acc;
  logic        wr;
  logic [7:0]  base;
  logic [1:0]  m0;
  logic [1:0]  m1;
  logic [1:0]  pre;
  logic [1:0]  inc;
  logic [1:0]  ext_ev;
  logic [1:0]  ie_nxt;
  logic        split;
  logic        inc_hi;
  logic        run1;
  logic [16:0] st0;
  logic [16:0] st1;
  logic [8:0]  hi_sum;
  logic        set_tf0;
  logic        set_tf1;
  logic [3:0]  ev;
  logic [3:0]  w1c;
  logic [31:0] rd;
  logic        hit;

  dtc_tick_if t ();

  // pins and prescaler live in their own small module
  dtc_sync u_sync (
    .pclk              (pclk),
    .presetn           (presetn),
    .ce                (ce),
    .count_pin         (count_pin),
    .ext_request_pin_n (ext_request_pin_n),
    .t                 (t)
  );

  // apb phases; one wait-free access after a setup cycle
  assign setup = psel & ~penable;
  assign acc   = psel & penable & s.rdy;
  assign wr    = acc & pwrite;

  // control byte as it stands after a software write
  assign base = (wr && paddr == OFS_CTRL) ? pwdata[7:0] : s.timer_run_and_flags;

  // mode fields of both timers
  assign m0 = s.mode[MODE_MSB:MODE_LSB];
  assign m1 = s.mode[NIB_W+MODE_MSB:NIB_W+MODE_LSB];

  // per timer: clock select, gate, source and request pin handling
  for (genvar i = 0; i < 2; i++) begin : g_tmr
    localparam int TR_B = CTRL_TR0 + CTRL_STRIDE * i;
    localparam int IE_B = CTRL_IE0 + CTRL_STRIDE * i;
    localparam int IT_B = CTRL_IT0 + CTRL_STRIDE * i;
    logic [3:0] nib;
    assign nib = s.mode[i*NIB_W +: NIB_W];
    // undivided clock counts every pclk
    assign pre[i] = s.aux[AUX_FAST0-i] | t.tick;
    // gate lets the request pin level qualify the run bit
    assign inc[i] = s.timer_run_and_flags[TR_B]
                  & (~nib[GATE_BIT] | t.ext_lvl[i])
                  & (nib[CT_BIT] ? t.cnt_fall[i] : pre[i]);
    // new request: an edge, or the pin newly found low in level mode
    assign ext_ev[i] = base[IT_B] ? t.ext_fall[i]
                     : (~t.ext_lvl[i] & ~s.timer_run_and_flags[IE_B]);
    // edge mode is sticky and cleared on vectoring; level mode follows the pin
    assign ie_nxt[i] = base[IT_B]
                     ? ((base[IE_B] & ~vec_ack[ACK_IE0+CTRL_STRIDE*i]) | t.ext_fall[i])
                     : ~t.ext_lvl[i];
  end

  // one count step for modes 0..3; bit 16 is the overflow
  function automatic logic [16:0] dtc_step(input logic [15:0] c,
                                           input logic [1:0]  m);
    logic [13:0] s13;
    logic [8:0]  lo;
    s13 = {1'b0, c[15:8], c[4:0]} + 14'h0001;
    lo  = {1'b0, c[7:0]} + 9'h001;
    unique case (m)
      // 13 bits: high byte and five low bits; bits 7:5 untouched
      MODE_13:     dtc_step = {s13[13], s13[12:5], c[7:5], s13[4:0]};
      MODE_16:     dtc_step = {1'b0, c} + 17'h0_0001;
      // reload low byte from high byte on overflow
      MODE_RELOAD: dtc_step = {lo[8], c[15:8], lo[8] ? c[15:8] : lo[7:0]};
      MODE_SPLIT:  dtc_step = {lo[8], c[15:8], lo[7:0]};
    endcase
  endfunction : dtc_step

  // counting, flags, register writes and read answer
  always_comb begin
    n      = s;
    st0    = dtc_step(s.cnt0, m0);
    st1    = dtc_step(s.cnt1, m1);
    hi_sum = {1'b0, s.cnt0[15:8]} + 9'h001;
    split  = (m0 == MODE_SPLIT);
    // split high byte: timer only, on second run bit, first clock select
    inc_hi = split & s.timer_run_and_flags[CTRL_TR1] & pre[0];
    run1   = inc[1] & (m1 != MODE_SPLIT);
    if (inc[0]) begin
      n.cnt0 = st0[15:0];
    end
    if (inc_hi) begin
      n.cnt0[15:8] = hi_sum[7:0];
    end
    if (run1) begin
      n.cnt1 = st1[15:0];
    end
    set_tf0 = inc[0] & st0[16];
    // second flag belongs to the split high byte while split
    set_tf1 = split ? (inc_hi & hi_sum[8]) : (run1 & st1[16]);

    // software writes; counts written here win over a count step
    w1c = '0;
    if (wr) begin
      case (paddr)
        OFS_MODE: n.mode        = pwdata[7:0];
        OFS_AUX:  n.aux         = pwdata[7:0] & AUX_MASK;
        OFS_T0L:  n.cnt0[7:0]   = pwdata[7:0];
        OFS_T0H:  n.cnt0[15:8]  = pwdata[7:0];
        OFS_T1L:  n.cnt1[7:0]   = pwdata[7:0];
        OFS_T1H:  n.cnt1[15:8]  = pwdata[7:0];
        OFS_STS:  w1c           = pwdata[3:0];
        OFS_MASK: n.mask        = pwdata[3:0];
        default:  n.mask        = s.mask;
      endcase
    end

    // flags: written value, then vectoring clear, then hardware set wins
    n.timer_run_and_flags = base;
    n.timer_run_and_flags[CTRL_TF0] = (base[CTRL_TF0] & ~vec_ack[ACK_TF0]) | set_tf0;
    n.timer_run_and_flags[CTRL_TF1] = (base[CTRL_TF1] & ~vec_ack[ACK_TF1]) | set_tf1;
    n.timer_run_and_flags[CTRL_IE0] = ie_nxt[0];
    n.timer_run_and_flags[CTRL_IE0+CTRL_STRIDE] = ie_nxt[1];

    // sticky status in acknowledge order; a new event beats its clear
    ev    = {set_tf1, ext_ev[1], set_tf0, ext_ev[0]};
    n.sts = (s.sts & ~w1c) | ev;
    n.irq = |(n.sts & n.mask);

    // answer is prepared in the setup cycle and shown in the access cycle
    n.rdy = setup;
    n.err = setup & ~hit;
    if (setup) begin
      n.rdata = rd;
    end
  end

  // read data mux; unmapped offsets answer zero with an error
  always_comb begin
    rd  = '0;
    hit = 1'b1;
    case (paddr)
      OFS_MODE: rd[7:0] = s.mode;
      OFS_CTRL: rd[7:0] = s.timer_run_and_flags;
      OFS_AUX:  rd[7:0] = s.aux;
      OFS_T0L:  rd[7:0] = s.cnt0[7:0];
      OFS_T0H:  rd[7:0] = s.cnt0[15:8];
      OFS_T1L:  rd[7:0] = s.cnt1[7:0];
      OFS_T1H:  rd[7:0] = s.cnt1[15:8];
      OFS_STS:  rd[3:0] = s.sts;
      OFS_MASK: rd[3:0] = s.mask;
      default:  hit     = 1'b0;
    endcase
  end

  // whole state in one register; ce low freezes everything, bus included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= ST_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign prdata   = s.rdata;
  assign pready   = s.rdy;
  assign pslverr  = s.err;
  assign irq      = s.irq;
  assign flag_req = {s.timer_run_and_flags[CTRL_TF1], s.timer_run_and_flags[CTRL_IE0+CTRL_STRIDE],
                     s.timer_run_and_flags[CTRL_TF0], s.timer_run_and_flags[CTRL_IE0]};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    ce && psel && !penable;
  endsequence

  sequence s_answer;
    pready && psel && penable;
  endsequence

  sequence s_wrap0;
    ce && inc[0] && !wr;
  endsequence

  apb_answer_a: assert property (s_setup |=> s_answer or !psel)
    else $error("no ready one cycle after setup");

  wrap_full_a: assert property (
    s_wrap0 and (m0 == MODE_16 && s.cnt0 == 16'hFFFF)
    |=> s.cnt0 == 16'h0000 && s.timer_run_and_flags[CTRL_TF0])
    else $error("16-bit wrap did not clear count and set flag");

  wrap_short_a: assert property (
    s_wrap0 and (m0 == MODE_13 && s.cnt0[15:8] == 8'hFF && s.cnt0[4:0] == 5'h1F)
    |=> s.cnt0[15:8] == 8'h00 && s.cnt0[4:0] == 5'h00 && s.timer_run_and_flags[CTRL_TF0])
    else $error("13-bit wrap wrong");

  reload_low_a: assert property (
    s_wrap0 and (m0 == MODE_RELOAD && s.cnt0[7:0] == 8'hFF)
    |=> s.cnt0[7:0] == $past(s.cnt0[15:8]) && $stable(s.cnt0[15:8]) && s.timer_run_and_flags[CTRL_TF0])
    else $error("reload did not copy high byte");

  run_off_a: assert property (
    ce && !s.timer_run_and_flags[CTRL_TR0] && m0 != MODE_SPLIT && !wr |=> $stable(s.cnt0))
    else $error("first timer counted while stopped");

  gate_hold_a: assert property (
    ce && s.mode[GATE_BIT] && !t.ext_lvl[0] && m0 != MODE_SPLIT && !wr |=> $stable(s.cnt0))
    else $error("gated timer counted with pin low");

  t1_hold_a: assert property (
    ce && m1 == MODE_SPLIT && !wr |=> $stable(s.cnt1))
    else $error("second timer moved in mode 3");

  fast_step_a: assert property (
    ce && s.aux[AUX_FAST0] && s.timer_run_and_flags[CTRL_TR0] && s.mode[NIB_W-1:0] == {2'b00, MODE_16}
    && s.cnt0 != 16'hFFFF && !wr |=> s.cnt0 == $past(s.cnt0) + 16'h0001)
    else $error("fast clock did not step every cycle");

  split_flag_a: assert property (
    ce && inc_hi && s.cnt0[15:8] == 8'hFF |=> s.timer_run_and_flags[CTRL_TF1])
    else $error("split high byte overflow missed second flag");

  ack_clear_a: assert property (
    ce && vec_ack[ACK_TF0] && !set_tf0 && !wr |=> !s.timer_run_and_flags[CTRL_TF0])
    else $error("vectoring left overflow flag set");

  level_follow_a: assert property (
    ce && !s.timer_run_and_flags[CTRL_IT0] && !wr |=> s.timer_run_and_flags[CTRL_IE0] == !$past(t.ext_lvl[0]))
    else $error("level request flag does not follow pin");

  irq_raise_a: assert property (
    ce && |(ev & n.mask) |=> irq)
    else $error("unmasked event did not raise irq");
endmodule : dtc_top
`default_nettype wire

// *** tb/dtc_pins_model.sv ***
// far-side pin model: count pins and active-low request pins
`timescale 1ns/1ns
`default_nettype none
module dtc_pins_model (
  // clock
  input  wire logic      pclk,
  // pins, idle high as if pulled up
  output var logic [1:0] count_pin,
  output var logic [1:0] ext_request_pin_n
);
  initial begin
    count_pin         = 2'b11;
    ext_request_pin_n = 2'b11;
  end
  // three cycles per level keeps well above the two-cycle minimum
  task automatic fall_count(input int i, input int n);
    repeat (n) begin
      count_pin[i] <= 1'b0;
      repeat (3) @(posedge pclk);
      count_pin[i] <= 1'b1;
      repeat (3) @(posedge pclk);
    end
  endtask : fall_count
  // request level changes only right after an edge
  task automatic set_req(input int i, input logic v);
    ext_request_pin_n[i] <= v;
    @(posedge pclk);
  endtask : set_req
endmodule : dtc_pins_model
`default_nettype wire

// *** tb/dual_timer_counter_tb.sv ***
// self-checking bench for the dual timer/counter
`timescale 1ns/1ns
`default_nettype none
module dual_timer_counter_tb;
  import dtc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, q2;
  logic        pready, pslverr, irq, e;
  logic [3:0]  vec_ack = 0, flag_req;
  wire  [1:0]  cpin, rpin;
  int          error_cnt = 0, checks = 0;
  // 125 MHz
  always #4 pclk = ~pclk;
  dtc_pins_model pins (.pclk(pclk), .count_pin(cpin), .ext_request_pin_n(rpin));
  dtc_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_pin(cpin), .ext_request_pin_n(rpin), .vec_ack(vec_ack),
    .flag_req(flag_req), .irq(irq));
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    checks++;
    if (y !== x) begin
      $display("[ERR] %s expected %h seen %h", nm, x, y);
      error_cnt++;
    end
  endtask : chk
  // apb transfer; pready sampled at the edge, request held until then
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
    if (n >= 20) begin chk("pready", 1, 0); finish_test(); end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); endtask : wr
  task automatic rd(input logic [7:0] a); apb(0, a, 0); endtask : rd
  // bounded wait for one flag output
  task automatic wait_flag(input int b);
    int n;
    for (n = 0; n < 200 && flag_req[b] !== 1'b1; n++) @(posedge pclk);
    if (n == 200) begin chk("flag wait", 1, 0); finish_test(); end
  endtask : wait_flag
  task automatic ack(input logic [3:0] v);
    vec_ack <= v;
    @(posedge pclk);
    vec_ack <= 0;
    repeat (2) @(posedge pclk);
  endtask : ack
  task automatic t_reset_map();
    for (int a = 0; a <= 32; a += 4) begin
      rd(8'(a));
      chk("reset value", 0, q);
      chk("slverr", 0, {31'h0, e});
    end
    rd(8'h24);
    chk("unmapped err", 1, {31'h0, e});
    wr(OFS_AUX, 32'h0000_00FF);
    rd(OFS_AUX);
    chk("aux bits", 32'h0000_00C0, q);
    $display("end reset_map");
  endtask : t_reset_map
  task automatic t_overflow_irq();
    wr(OFS_MODE, 32'h0000_0001); wr(OFS_T0L, 32'h0000_00FF); wr(OFS_T0H, 32'h0000_00FF);
    wr(OFS_AUX, 32'h0000_0080); wr(OFS_MASK, 0);
    wr(OFS_CTRL, 32'h0000_0010);
    wait_flag(1);
    repeat (2) @(posedge pclk);
    chk("irq masked", 0, {31'h0, irq});
    wr(OFS_MASK, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk("irq on", 1, {31'h0, irq});
    rd(OFS_CTRL);
    chk("ovf bit", 1, {31'h0, q[CTRL_TF0]});
    ack(4'b0010);
    rd(OFS_CTRL);
    chk("ovf acked", 0, {31'h0, q[CTRL_TF0]});
    wr(OFS_STS, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 0, {31'h0, irq});
    wr(OFS_CTRL, 32'h0000_0020);
    repeat (2) @(posedge pclk);
    chk("sw flag", 1, {31'h0, flag_req[1]});
    wr(OFS_CTRL, 0);
    rd(OFS_T0L); q2 = q;
    repeat (10) @(posedge pclk);
    rd(OFS_T0L);
    chk("stopped", q2, q);
    $display("end overflow_irq");
  endtask : t_overflow_irq
  task automatic t_reload();
    wr(OFS_MODE, 32'h0000_0020); wr(OFS_T1H, 32'h0000_00F0); wr(OFS_T1L, 32'h0000_00FE);
    wr(OFS_AUX, 32'h0000_0040); wr(OFS_CTRL, 32'h0000_0040);
    wait_flag(3);
    wr(OFS_CTRL, 0);
    rd(OFS_T1H);
    chk("high kept", 32'h0000_00F0, q);
    rd(OFS_T1L);
    chk("low reloaded", 4'hF, {28'h0, q[7:4]});
    $display("end reload");
  endtask : t_reload
  task automatic t_counter();
    wr(OFS_MODE, 32'h0000_0005); wr(OFS_T0L, 0); wr(OFS_T0H, 0); wr(OFS_CTRL, 32'h0000_0010);
    pins.fall_count(0, 3);
    repeat (6) @(posedge pclk);
    rd(OFS_T0L);
    chk("edge count", 3, q);
    $display("end counter");
  endtask : t_counter
  task automatic t_gate_level();
    wr(OFS_MODE, 32'h0000_0009); wr(OFS_AUX, 32'h0000_0080); wr(OFS_CTRL, 32'h0000_0010);
    pins.set_req(0, 0);
    repeat (5) @(posedge pclk);
    rd(OFS_T0L); q2 = q;
    repeat (10) @(posedge pclk);
    rd(OFS_T0L);
    chk("gate shut", q2, q);
    chk("level flag", 1, {31'h0, flag_req[0]});
    ack(4'b0001);
    chk("level keeps", 1, {31'h0, flag_req[0]});
    pins.set_req(0, 1);
    repeat (6) @(posedge pclk);
    chk("level drops", 0, {31'h0, flag_req[0]});
    rd(OFS_T0L);
    chk("gate open", 1, {31'h0, q != q2});
    $display("end gate_level");
  endtask : t_gate_level
  task automatic t_edge_req();
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL, 32'(1) << (2 * i));
      pins.set_req(i, 0);
      repeat (3) @(posedge pclk);
      pins.set_req(i, 1);
      wait_flag(2 * i);
      ack(4'(1) << (2 * i));
      chk("edge flag acked", 0, {31'h0, flag_req[2*i]});
    end
    $display("end edge_req");
  endtask : t_edge_req
  task automatic t_split();
    wr(OFS_MODE, 32'h0000_0033); wr(OFS_T0H, 32'h0000_00FE); wr(OFS_T1L, 32'h0000_0055);
    wr(OFS_AUX, 32'h0000_0080); wr(OFS_CTRL, 32'h0000_0040);
    wait_flag(3);
    chk("low idle", 0, {31'h0, flag_req[1]});
    rd(OFS_T1L);
    chk("second held", 32'h0000_0055, q);
    wr(OFS_CTRL, 0);
    $display("end split");
  endtask : t_split
  task automatic t_short();
    wr(OFS_MODE, 0); wr(OFS_AUX, 32'h0000_0080); wr(OFS_T0H, 32'h0000_00FF); wr(OFS_T0L, 32'h0000_00FF);
    wr(OFS_CTRL, 32'h0000_0010);
    wait_flag(1);
    wr(OFS_CTRL, 0);
    rd(OFS_T0L);
    chk("short low top", 32'h0000_0007, {29'h0, q[7:5]});
    rd(OFS_T0H);
    chk("short high", 0, q);
    $display("end short");
  endtask : t_short
  task automatic t_slow();
    wr(OFS_MODE, 32'h0000_0001); wr(OFS_AUX, 0); wr(OFS_T0L, 0); wr(OFS_T0H, 0);
    wr(OFS_CTRL, 32'h0000_0010);
    repeat (120) @(posedge pclk);
    wr(OFS_CTRL, 0);
    rd(OFS_T0L);
    chk("slow rate", 1, {31'h0, q >= 9 && q <= 11});
    $display("end slow");
  endtask : t_slow
  // main sequence: reset held four cycles, then scenarios
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset_map();
    t_overflow_irq();
    t_reload();
    t_counter();
    t_gate_level();
    t_edge_req();
    t_split();
    t_short();
    t_slow();
    finish_test();
  end
endmodule : dual_timer_counter_tb
`default_nettype wire
